// ### bme_encoder.sv
// Biphase-mark encoder with LED output steering and an AHB-Lite register slave.
// Assumes bit clock and data pins are synchronous to core_clk and slower than a quarter of it.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "bme_defs.svh"

module bme_encoder
  import bme_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // TTL input pair
  input wire logic ttl_serial_in,
  input wire logic ttl_bit_clock,
  // ECL input pair
  input wire logic ecl_serial_in,
  input wire logic ecl_bit_clock,
  // Static controls
  input wire logic driver_enable_n_off,
  input wire logic large_output_select_strap,
  // LED current switches
  output logic small_led_out,
  output logic large_led_out,
  output logic dummy_load_out
);

  // ==========================================
  // Register read mux, shared by the bus decode
  function automatic logic [31:0] bme_rd_mux(
    input logic [7:0] a,
    input logic [1:0] ctrl,
    input logic [5:0] stat,
    input logic [31:0] cnt
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `BME_CTRL_OFS: v = {30'h0, ctrl};
      `BME_STATUS_OFS: v = {26'h0, stat};
      `BME_BITCNT_OFS: v = cnt;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : bme_rd_mux

  // ==========================================
  // State
  logic [1:0] ctrl_reg;
  logic [31:0] bitcnt_reg;
  logic [31:0] hrdata_reg;
  bme_ahb_req_t req_reg;
  logic req_valid_reg;
  logic clk_prev_reg;
  logic enc_reg;
  logic last_bit_reg;
  logic strap_large_reg;
  logic strap_done_reg;
  bme_drive_t drive_reg;

  // ==========================================
  // Input pair selection; the idle pair is pulled down, so software picks one
  bme_pair_t ttl_pair;
  bme_pair_t ecl_pair;
  bme_pair_t sel_pair;
  bme_pair_sel_t pair_sel;
  assign ttl_pair = '{data: ttl_serial_in, clk: ttl_bit_clock};
  assign ecl_pair = '{data: ecl_serial_in, clk: ecl_bit_clock};
  assign pair_sel = bme_pair_sel_t'(ctrl_reg[`BME_CTRL_PAIR]);
  assign sel_pair = (pair_sel == BME_PAIR_ECL) ? ecl_pair : ttl_pair;

  // Edge detection against the previous sample of the chosen bit clock
  logic bit_rise;
  logic bit_fall;
  assign bit_rise = sel_pair.clk & ~clk_prev_reg;
  assign bit_fall = ~sel_pair.clk & clk_prev_reg;

  // ==========================================
  // Biphase-mark encoding
  logic enc_next;
  assign enc_next = bit_fall ? ~enc_reg :
                    (bit_rise & sel_pair.data) ? ~enc_reg :
                    enc_reg;

  // Output steering, registered so the pins never glitch on decode
  logic drv_en;
  bme_drive_t drive_next;
  assign drv_en = driver_enable_n_off & ctrl_reg[`BME_CTRL_EN];
  assign drive_next.small_on = drv_en & enc_next & ~strap_large_reg;
  assign drive_next.large_on = drv_en & enc_next & strap_large_reg;
  assign drive_next.dummy_on = drv_en & ~enc_next;

  // ==========================================
  // AHB-Lite decode: zero wait states, always OKAY
  logic addr_take;
  logic wr_take;
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_take = req_valid_reg & req_reg.write & req_reg.word;

  logic ctrl_wr;
  logic cnt_clr;
  assign ctrl_wr = wr_take & (req_reg.addr == `BME_CTRL_OFS);
  assign cnt_clr = wr_take & (req_reg.addr == `BME_BITCNT_OFS);

  logic [5:0] status_word;
  assign status_word = {ctrl_reg[`BME_CTRL_PAIR], driver_enable_n_off, last_bit_reg,
                        drv_en, strap_large_reg, enc_reg};

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign small_led_out = drive_reg.small_on;
  assign large_led_out = drive_reg.large_on;
  assign dummy_load_out = drive_reg.dummy_on;

  // Bus phase tracking and registered read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_valid_reg <= 1'b0;
      req_reg <= '0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      req_valid_reg <= addr_take;
      if (addr_take) begin
        req_reg <= '{addr: haddr[7:0], write: hwrite, word: (hsize == `BME_HSIZE_WORD)};
        hrdata_reg <= bme_rd_mux(haddr[7:0], ctrl_reg, status_word, bitcnt_reg);
      end
    end
  end

  // Control register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= `BME_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= hwdata[1:0];
    end
  end

  // Bit counter: a capture in the clearing cycle is kept, clear wins over the increment
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bitcnt_reg <= `BME_BITCNT_RST;
    end else if (cnt_clr) begin
      bitcnt_reg <= {31'h0, bit_rise};
    end else if (bit_rise) begin
      bitcnt_reg <= bitcnt_reg + 32'h0000_0001;
    end
  end

  // Strap is caught once, on the first edge after reset release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      strap_large_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_large_reg <= large_output_select_strap;
    end
  end

  // Encoder core; reset level is arbitrary for the far end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_prev_reg <= 1'b0;
      enc_reg <= `BME_ENC_RST;
      last_bit_reg <= 1'b0;
      drive_reg <= '0;
    end else begin
      clk_prev_reg <= sel_pair.clk;
      enc_reg <= enc_next;
      drive_reg <= drive_next;
      if (bit_rise) begin
        last_bit_reg <= sel_pair.data;
      end
    end
  end

  // ==========================================
  // Assertions
  localparam int C_MIN_HALF = `BME_MIN_HALF_CYC;
  localparam int C_MAX_HALF = 8;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_capture;
    bit_rise |=> last_bit_reg == $past(sel_pair.data);
  endproperty
  a_capture: assert property (p_capture) else $error("bit not captured on rise");

  property p_one_toggles;
    bit_rise && sel_pair.data |=> enc_reg != $past(enc_reg);
  endproperty
  a_one_toggles: assert property (p_one_toggles) else $error("one did not invert state");

  property p_zero_holds;
    bit_rise && !sel_pair.data |=> $stable(enc_reg);
  endproperty
  a_zero_holds: assert property (p_zero_holds) else $error("zero changed state");

  property p_fall_toggles;
    bit_fall |=> enc_reg != $past(enc_reg);
  endproperty
  a_fall_toggles: assert property (p_fall_toggles) else $error("fall did not invert state");

  property p_disable_off;
    !driver_enable_n_off |=> !small_led_out && !large_led_out;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("led driven while disabled");

  property p_complement;
    drv_en |=> (dummy_load_out == !enc_reg) && ((small_led_out | large_led_out) == enc_reg);
  endproperty
  a_complement: assert property (p_complement) else $error("dummy load not complementary");

  property p_strap_route;
    strap_done_reg |-> !(strap_large_reg ? small_led_out : large_led_out);
  endproperty
  a_strap_route: assert property (p_strap_route) else $error("wrong led output used");

  property p_count;
    bit_rise && !cnt_clr |=> bitcnt_reg == $past(bitcnt_reg) + 32'h0000_0001;
  endproperty
  a_count: assert property (p_count) else $error("bit not counted");

  property p_only_edges;
    !bit_rise && !bit_fall |=> $stable(enc_reg);
  endproperty
  a_only_edges: assert property (p_only_edges) else $error("state moved without edge");

  // Enabled drivers follow the encoded state; disabled ones switch all outputs off, dummy load included
  property p_pin_enable;
    driver_enable_n_off && ctrl_reg[`BME_CTRL_EN] && enc_next |=> small_led_out || large_led_out;
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("enabled led not driven");

  property p_dummy_off;
    !drv_en |=> !dummy_load_out;
  endproperty
  a_dummy_off: assert property (p_dummy_off) else $error("dummy load on while disabled");

  // The strap is static: once caught it must not follow the pin
  property p_strap_hold;
    strap_done_reg |=> $stable(strap_large_reg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap choice moved");

  // Bit counter bookkeeping, a capture in the clearing cycle included
  property p_clear;
    cnt_clr |=> bitcnt_reg == {31'h0, $past(bit_rise)};
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  property p_count_holds;
    !bit_rise && !cnt_clr |=> $stable(bitcnt_reg);
  endproperty
  a_count_holds: assert property (p_count_holds) else $error("count moved without capture");

  property p_last_holds;
    !bit_rise |=> $stable(last_bit_reg);
  endproperty
  a_last_holds: assert property (p_last_holds) else $error("captured bit moved without edge");

  // Register bus: word writes land in the data phase, narrow ones are dropped
  property p_ctrl_write;
    ctrl_wr |=> ctrl_reg == $past(hwdata[1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_narrow_ignored;
    req_valid_reg && req_reg.write && !req_reg.word |=> $stable(ctrl_reg);
  endproperty
  a_narrow_ignored: assert property (p_narrow_ignored) else $error("narrow write changed control");

  // Read data is taken in the address phase, so it shows that cycle's value
  property p_rd_ctrl;
    addr_take && haddr[7:0] == `BME_CTRL_OFS |=> hrdata == {30'h0, $past(ctrl_reg)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read data wrong");

  c_one_bit: cover property (bit_rise && sel_pair.data ##[C_MIN_HALF:C_MAX_HALF] bit_fall);
  c_zero_bit: cover property (bit_rise && !sel_pair.data ##[C_MIN_HALF:C_MAX_HALF] bit_fall);
  c_large_on: cover property (large_led_out ##[C_MIN_HALF:C_MAX_HALF] dummy_load_out);
  c_ecl_rise: cover property (pair_sel == BME_PAIR_ECL && bit_rise);
  c_disabled: cover property (drv_en ##1 !drv_en);

endmodule : bme_encoder

// ### bme_defs.svh
// Constants of the biphase-mark encoder: offsets, fields, reset values, timing.
// Assumes inclusion by bare name; holds definitions only.
`ifndef BME_DEFS_SVH
`define BME_DEFS_SVH

// ==========================================
// Register offsets (byte addresses, low 8 bits of haddr)
`define BME_CTRL_OFS 8'h00
`define BME_STATUS_OFS 8'h04
`define BME_BITCNT_OFS 8'h08

// ==========================================
// Field positions
`define BME_CTRL_PAIR 0
`define BME_CTRL_EN 1
`define BME_STAT_ENC 0
`define BME_STAT_LARGE 1
`define BME_STAT_DRV 2
`define BME_STAT_LAST 3
`define BME_STAT_PIN_EN 4
`define BME_STAT_PAIR 5

// ==========================================
// Reset values and the hsize code of a word transfer
`define BME_CTRL_RST 2'h2
`define BME_ENC_RST 1'h0
`define BME_BITCNT_RST 32'h0000_0000
`define BME_HSIZE_WORD 3'h2

// ==========================================
// Timing: rates as printed, cycle count derived (least time, rounded up)
`define BME_CLK_MHZ 200
`define BME_MAX_RATE_MBPS 50
`define BME_MIN_HALF_CYC ((`BME_CLK_MHZ + 2 * `BME_MAX_RATE_MBPS - 1) / (2 * `BME_MAX_RATE_MBPS))

`endif

// ### bme_pkg.sv
// Types shared by the biphase-mark encoder.
// Assumes bme_defs.svh is compiled alongside.
package bme_pkg;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic data;
    logic clk;
  } bme_pair_t;

  typedef struct packed {
    logic small_on;
    logic large_on;
    logic dummy_on;
  } bme_drive_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic word;
  } bme_ahb_req_t;

  // Input pair choice, one bit of the control register
  typedef enum logic {
    BME_PAIR_TTL = 1'b0,
    BME_PAIR_ECL = 1'b1
  } bme_pair_sel_t;

endpackage : bme_pkg

// ### bme_host_model.sv
// Host data source for the encoder bench: drives one input pair a bit at a time.
// Assumes the bench calls rise then fall from one process, right after a clock edge.
`timescale 1ns/1ps
module bme_host_model
  import bme_pkg::*;
(
  // Core clock
  input wire logic core_clk,
  // Input pairs
  output bme_pair_t ttl_pair,
  output bme_pair_t ecl_pair
);
  // ==========================================
  // Unused pins rest at their pull-down level, bit clock still between bits
  initial begin
    ttl_pair = 2'h0;
    ecl_pair = 2'h0;
  end

  // Data set up one cycle ahead, then clock high for three cycles
  task automatic rise(input logic b, input logic use_ecl);
    @(posedge core_clk);
    if (use_ecl) ecl_pair.data <= b;
    else ttl_pair.data <= b;
    @(posedge core_clk);
    if (use_ecl) ecl_pair.clk <= 1'b1;
    else ttl_pair.clk <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rise

  // Clock low and data released to the pull-down level
  task automatic fall(input logic use_ecl);
    @(posedge core_clk);
    if (use_ecl) ecl_pair <= 2'h0;
    else ttl_pair <= 2'h0;
    repeat (3) @(posedge core_clk);
  endtask : fall
endmodule : bme_host_model

// ### bme_encoder_tb.sv
// Self-checking bench for the biphase-mark encoder: a table of bits, then bus and reset cases.
// Assumes the bench is the only AHB-Lite master and the host model drives the pairs.
`timescale 1ns/1ps
module bme_encoder_tb
  import bme_pkg::*;
;
  typedef struct packed {
    logic b;
    logic pin_en;
    bme_drive_t rise_exp;
    bme_drive_t fall_exp;
  } bme_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic drv_en_pin = 1'b1;
  logic strap = 1'b0;
  logic hreadyout, hresp, small_led_out, large_led_out, dummy_load_out;
  logic [31:0] hrdata;
  logic [31:0] rd_val;
  logic line_prev;
  bme_pair_t ttl_pair;
  bme_pair_t ecl_pair;
  int num_errors = 0;
  int samples_checked = 0;
  // Drive expectations as {small, large, dummy}, starting from state 0
  bme_row_t rows [6] = '{'{1'b1, 1'b1, 3'h4, 3'h1}, '{1'b0, 1'b1, 3'h1, 3'h4}, '{1'b1, 1'b1, 3'h1, 3'h4},
    '{1'b0, 1'b0, 3'h0, 3'h0}, '{1'b1, 1'b1, 3'h4, 3'h1}, '{1'b0, 1'b1, 3'h1, 3'h4}};

  always #2.5 core_clk = ~core_clk;

  // ==========================================
  // Design and host
  bme_encoder bme_encoder_i (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ttl_serial_in(ttl_pair.data), .ttl_bit_clock(ttl_pair.clk),
    .ecl_serial_in(ecl_pair.data), .ecl_bit_clock(ecl_pair.clk), .driver_enable_n_off(drv_en_pin),
    .large_output_select_strap(strap), .small_led_out(small_led_out), .large_led_out(large_led_out),
    .dummy_load_out(dummy_load_out));
  bme_host_model bme_host_model_i (.core_clk(core_clk), .ttl_pair(ttl_pair), .ecl_pair(ecl_pair));

  // ==========================================
  // Reporting
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : check_word

  task automatic check_leds(input string what, input bme_drive_t exp);
    samples_checked++;
    if ({small_led_out, large_led_out, dummy_load_out} !== exp) begin
      $display("mismatch %s expected %b seen %b", what, exp, {small_led_out, large_led_out, dummy_load_out});
      num_errors++;
    end
  endtask : check_leds

  // ==========================================
  // Bus master: a bounded wait guards against a slave that never answers
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask : wait_ready

  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [2:0] sz, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd_val = hrdata;
  endtask : bus_xfer

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 3'h2, 32'h0);
    check_word(what, exp, rd_val);
    check_word("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk

  task automatic settle_chk(input string what, input bme_drive_t exp);
    repeat (2) @(posedge core_clk);
    check_leds(what, exp);
  endtask : settle_chk

  // ==========================================
  // Main sequence: reset reads, then table rows, then the awkward cases
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk("ctrl reset", 8'h00, 32'h2);
    rd_chk("count reset", 8'h08, 32'h0);
    foreach (rows[i]) begin
      drv_en_pin <= rows[i].pin_en;
      line_prev = dummy_load_out;
      bme_host_model_i.rise(rows[i].b, 1'b0);
      check_leds("rise", rows[i].rise_exp);
      // A far decoder sees a one only as a mid-bit transition, whatever the level
      if (rows[i].pin_en && (i == 0 || rows[i - 1].pin_en))
        check_word("mid-bit", {31'h0, rows[i].b}, {31'h0, line_prev ^ dummy_load_out});
      bme_host_model_i.fall(1'b0);
      check_leds("fall", rows[i].fall_exp);
    end
    rd_chk("status", 8'h04, 32'h15);
    rd_chk("count", 8'h08, 32'h6);
    bus_xfer(1'b1, 8'h08, 3'h2, 32'hFFFF_FFFF);
    rd_chk("count cleared", 8'h08, 32'h0);
    bus_xfer(1'b1, 8'h00, 3'h2, 32'h0);
    settle_chk("soft off", 3'h0);
    bus_xfer(1'b1, 8'h00, 3'h0, 32'h3);
    rd_chk("narrow write", 8'h00, 32'h0);
    bus_xfer(1'b1, 8'h00, 3'h2, 32'h3);
    settle_chk("ecl on", 3'h4);
    bme_host_model_i.rise(1'b1, 1'b1);
    check_leds("ecl rise", 3'h1);
    bme_host_model_i.rise(1'b1, 1'b0);
    check_leds("ttl ignored", 3'h1);
    bme_host_model_i.fall(1'b0);
    bme_host_model_i.fall(1'b1);
    check_leds("ecl fall", 3'h4);
    rd_chk("ecl count", 8'h08, 32'h1);
    rd_chk("unmapped", 8'h0C, 32'h0);
    // Strap is only taken after reset, so the large path needs a second reset
    strap <= 1'b1;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    settle_chk("large idle", 3'h1);
    bme_host_model_i.rise(1'b1, 1'b0);
    check_leds("large rise", 3'h2);
    rd_chk("status large", 8'h04, 32'h1F);
    bme_host_model_i.fall(1'b0);
    check_leds("large fall", 3'h1);
    conclude();
  end
endmodule : bme_encoder_tb
